/* File: rtl/oss_defines.svh */
// Register offsets, field positions, reset values and code limits
`ifndef OSS_DEFINES_SVH
`define OSS_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OSS_ADDR_SELECT_A 8'h00
`define OSS_ADDR_SELECT_B 8'h04
`define OSS_ADDR_SELECT_C 8'h08
`define OSS_ADDR_MODE_DIFF 8'h0C
`define OSS_ADDR_MODE_LOGIC 8'h10
`define OSS_ADDR_MODE_THIRD 8'h14
`define OSS_ADDR_STATUS 8'h18

// ****************************************************************
// Field layout
// ****************************************************************
`define OSS_GROUPS 12
`define OSS_GROUPS_PER_REG 4
`define OSS_SEL_WIDTH 8
`define OSS_MODE_WIDTH 2
`define OSS_STATUS_VARIANT_LSB 16
`define OSS_ISOLATED_GROUPS 8

// ****************************************************************
// Reset values
// ****************************************************************
`define OSS_SELECT_RESET 32'h0000_0000
`define OSS_MODE_RESET 32'h0000_0000

// ****************************************************************
// Source code table limits
// ****************************************************************
`define OSS_CODE_GRABBER1 8'h04
`define OSS_CODE_GRABBER3 8'h0C
`define OSS_CODE_SEQUENCER 8'h10
`define OSS_CODE_FIRST_RESERVED 8'h14
`define OSS_SOURCE_COUNT 20

`endif

/* File: rtl/oss_pkg.sv */
// Types and the shared source code check
`include "oss_defines.svh"

package oss_pkg;

    // Product variant by number of grabbers
    typedef enum logic [1:0] {
        OSS_GRAB1 = 2'b00,
        OSS_GRAB3 = 2'b01,
        OSS_GRAB4 = 2'b10
    } oss_variant_t;

    // Per-output drive mode
    typedef enum logic [1:0] {
        OSS_LOW  = 2'b00,
        OSS_HIGH = 2'b01,
        OSS_DYN  = 2'b10,
        OSS_RSVD = 2'b11
    } oss_mode_t;

    // Bus response codes
    typedef enum logic [1:0] {
        OSS_OKAY   = 2'b00,
        OSS_SLVERR = 2'b10
    } oss_resp_t;

    // True when a code selects a source present on this variant
    function automatic logic oss_code_usable(input logic [7:0] code,
                                             input oss_variant_t variant);
        logic usable;
        usable = (code < `OSS_CODE_FIRST_RESERVED);
        // RQ4 one grabber
        if (variant == OSS_GRAB1 && code >= `OSS_CODE_GRABBER1 &&
            code < `OSS_CODE_SEQUENCER) begin
            usable = 1'b0;
        end
        // RQ5 three grabbers
        if (variant == OSS_GRAB3 && code >= `OSS_CODE_GRABBER3 &&
            code < `OSS_CODE_SEQUENCER) begin
            usable = 1'b0;
        end
        return usable;
    endfunction

endpackage

/* File: rtl/oss_group_mux.sv */
// One output group: source pick and three registered drivers
`timescale 1ns/1ps

module oss_group_mux (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Selection
    input wire logic [7:0] sourceCode,
    input wire oss_pkg::oss_variant_t variant,
    input wire logic [19:0] sources,
    // Modes of the three outputs
    input wire oss_pkg::oss_mode_t diffMode,
    input wire oss_pkg::oss_mode_t logicMode,
    input wire oss_pkg::oss_mode_t thirdMode,
    // Outputs
    output logic diffOut,
    output logic logicOut,
    output logic thirdOut,
    output logic codeUsable
);
    import oss_pkg::*;

    logic dynSource;

    // ****************************************************************
    // Dynamic source
    // ****************************************************************
    // RQ3 RQ11 code picks source
    always_comb begin
        dynSource = 1'b0;
        if (oss_code_usable(sourceCode, variant)) begin
            dynSource = sources[sourceCode[4:0]];
        end
    end

    // Drive level for one output from its mode
    function automatic logic drive(input oss_mode_t mode, input logic dyn);
        logic level;
        level = 1'b0;
        unique case (mode)
            OSS_LOW: level = 1'b0;
            OSS_HIGH: level = 1'b1;
            OSS_DYN: level = dyn;
            OSS_RSVD: level = 1'b0;
        endcase
        return level;
    endfunction

    // ****************************************************************
    // Output registers
    // ****************************************************************
    // RQ2 shared source, own modes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            diffOut <= 1'b0;
            logicOut <= 1'b0;
            thirdOut <= 1'b0;
            codeUsable <= 1'b0;
        end else begin
            diffOut <= drive(diffMode, dynSource);
            logicOut <= drive(logicMode, dynSource);
            thirdOut <= drive(thirdMode, dynSource);
            codeUsable <= oss_code_usable(sourceCode, variant);
        end
    end

endmodule // oss_group_mux

/* File: rtl/oss_output_source_select.sv */
// Output source select: register slave and twelve group routers
// Summary of operation
// RQ1: Selector picks one source per group.
// RQ2: Group outputs share source; modes independent.
// RQ3: Codes 0-15 grabber lines, 16-19 sequencer.
// RQ4: One-grabber variant blocks codes 4-15.
// RQ5: Three-grabber variant blocks codes 12-15.
// RQ6: Register A holds groups 0-3.
// RQ7: Register B holds groups 4-7.
// RQ8: Register C groups 8-11, open-collector.
// RQ9: All groups decode one code table.
// RQ10: Mode 00 low, 01 high, 10 dynamic.
// RQ11: Reserved or unavailable code drives low.
`timescale 1ns/1ps
`include "oss_defines.svh"

module oss_output_source_select #(
    parameter oss_pkg::oss_variant_t VARIANT = oss_pkg::OSS_GRAB4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timing sources
    input wire logic [15:0] cameraControl,
    input wire logic [3:0] sequencerOut,
    // Box outputs
    output logic [11:0] differentialOut,
    output logic [11:0] logicLevelOut,
    output logic [7:0] isolatedOut,
    output logic [3:0] openCollectorOut
);
    import oss_pkg::*;

    logic [31:0] selectA;
    logic [31:0] selectB;
    logic [31:0] selectC;
    logic [31:0] modeDiff;
    logic [31:0] modeLogic;
    logic [31:0] modeThird;
    logic [7:0] writeAddr;
    logic [31:0] writeData;
    logic [3:0] writeStrb;
    logic doWrite;
    logic [95:0] allSelect;
    logic [11:0] thirdOut;
    logic [11:0] usable;
    logic [19:0] sources;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Merge write data into a register under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] result;
        result = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                result[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return result;
    endfunction

    // True for an offset that holds a register
    function automatic logic mapped(input logic [7:0] addr);
        return addr == `OSS_ADDR_SELECT_A || addr == `OSS_ADDR_SELECT_B ||
            addr == `OSS_ADDR_SELECT_C || addr == `OSS_ADDR_MODE_DIFF ||
            addr == `OSS_ADDR_MODE_LOGIC || addr == `OSS_ADDR_MODE_THIRD ||
            addr == `OSS_ADDR_STATUS;
    endfunction

    // ****************************************************************
    // Write channel
    // ****************************************************************
    // Both halves held and no response pending
    assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // Address and data are taken in either order and held
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            writeAddr <= 8'h00;
            writeData <= 32'h0000_0000;
            writeStrb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                writeAddr <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                writeData <= s_axi_wdata;
                writeStrb <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response, error for an unmapped or read-only offset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= OSS_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (mapped(writeAddr) &&
                writeAddr != `OSS_ADDR_STATUS) ? OSS_OKAY : OSS_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // RQ6 RQ7 RQ8 selector registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            selectA <= `OSS_SELECT_RESET;
            selectB <= `OSS_SELECT_RESET;
            selectC <= `OSS_SELECT_RESET;
        end else if (doWrite) begin
            if (writeAddr == `OSS_ADDR_SELECT_A) begin
                selectA <= merge(selectA, writeData, writeStrb);
            end
            if (writeAddr == `OSS_ADDR_SELECT_B) begin
                selectB <= merge(selectB, writeData, writeStrb);
            end
            if (writeAddr == `OSS_ADDR_SELECT_C) begin
                selectC <= merge(selectC, writeData, writeStrb);
            end
        end
    end

    // RQ10 two mode bits per output
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            modeDiff <= `OSS_MODE_RESET;
            modeLogic <= `OSS_MODE_RESET;
            modeThird <= `OSS_MODE_RESET;
        end else if (doWrite) begin
            if (writeAddr == `OSS_ADDR_MODE_DIFF) begin
                modeDiff <= merge(modeDiff, writeData, writeStrb);
            end
            if (writeAddr == `OSS_ADDR_MODE_LOGIC) begin
                modeLogic <= merge(modeLogic, writeData, writeStrb);
            end
            if (writeAddr == `OSS_ADDR_MODE_THIRD) begin
                modeThird <= merge(modeThird, writeData, writeStrb);
            end
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    // One read at a time, data one cycle after the address
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= OSS_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? OSS_OKAY : OSS_SLVERR;
            unique case (s_axi_araddr)
                `OSS_ADDR_SELECT_A: s_axi_rdata <= selectA;
                `OSS_ADDR_SELECT_B: s_axi_rdata <= selectB;
                `OSS_ADDR_SELECT_C: s_axi_rdata <= selectC;
                `OSS_ADDR_MODE_DIFF: s_axi_rdata <= modeDiff;
                `OSS_ADDR_MODE_LOGIC: s_axi_rdata <= modeLogic;
                `OSS_ADDR_MODE_THIRD: s_axi_rdata <= modeThird;
                `OSS_ADDR_STATUS: s_axi_rdata <= {14'h0000, VARIANT,
                    4'h0, usable};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // Group routing
    // ****************************************************************
    // RQ9 one table for all groups
    assign allSelect = {selectC, selectB, selectA};
    assign sources = {sequencerOut, cameraControl};

    // RQ1 one router per group
    for (genvar g = 0; g < `OSS_GROUPS; g++) begin : gGroup
        oss_group_mux uMux (
            .clk_sys(clk_sys),
            .srst(srst),
            .sourceCode(allSelect[g*8 +: 8]),
            .variant(VARIANT),
            .sources(sources),
            .diffMode(oss_mode_t'(modeDiff[g*2 +: 2])),
            .logicMode(oss_mode_t'(modeLogic[g*2 +: 2])),
            .thirdMode(oss_mode_t'(modeThird[g*2 +: 2])),
            .diffOut(differentialOut[g]),
            .logicOut(logicLevelOut[g]),
            .thirdOut(thirdOut[g]),
            .codeUsable(usable[g])
        );
    end

    // RQ8 upper groups drive open-collector outputs
    assign isolatedOut = thirdOut[7:0];
    assign openCollectorOut = thirdOut[11:8];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // RQ10 static low mode
    mode_low_a: assert property (modeDiff[1:0] == 2'b00 // RQ10
        |=> !differentialOut[0]) else $error("static low not low");

    // RQ10 static high mode
    mode_high_a: assert property (modeLogic[3:2] == 2'b01 // RQ10
        |=> logicLevelOut[1]) else $error("static high not high");

    // RQ3 grabber line routing
    route_camera_a: assert property ( // RQ3
        modeDiff[1:0] == 2'b10 && selectA[7:0] < 8'h10 &&
        oss_code_usable(selectA[7:0], VARIANT)
        |=> differentialOut[0] == $past(cameraControl[selectA[3:0]]))
        else $error("camera line not routed");

    // RQ3 sequencer routing
    route_sequencer_a: assert property ( // RQ3
        modeLogic[1:0] == 2'b10 && selectA[7:2] == 6'b000100
        |=> logicLevelOut[0] == $past(sequencerOut[selectA[1:0]]))
        else $error("sequencer output not routed");

    // RQ2 shared source within a group
    group_shared_a: assert property ( // RQ2
        modeDiff[3:2] == 2'b10 && modeLogic[3:2] == 2'b10 &&
        modeThird[3:2] == 2'b10
        |=> differentialOut[1] == logicLevelOut[1] &&
        logicLevelOut[1] == isolatedOut[1])
        else $error("group outputs differ");

    // RQ11 reserved code gives low
    reserved_low_a: assert property ( // RQ11
        modeDiff[5:4] == 2'b10 && selectA[23:16] >= 8'h14
        |=> !differentialOut[2]) else $error("reserved code not low");

    // RQ4 single grabber variant
    one_grabber_a: assert property ( // RQ4
        VARIANT == OSS_GRAB1 && modeDiff[7:6] == 2'b10 &&
        selectA[31:24] >= 8'h04 && selectA[31:24] < 8'h10
        |=> !differentialOut[3]) else $error("grabber 1-3 not blocked");

    // RQ5 three grabber variant
    three_grabber_a: assert property ( // RQ5
        VARIANT != OSS_GRAB4 && modeDiff[7:6] == 2'b10 &&
        selectA[31:24] >= 8'h0C && selectA[31:24] < 8'h10
        |=> !differentialOut[3]) else $error("grabber 3 not blocked");

    // RQ7 second register lane to group 4
    reg_b_lane_a: assert property ( // RQ7
        modeThird[9:8] == 2'b10 && selectB[7:0] == 8'h10
        |=> isolatedOut[4] == $past(sequencerOut[0]))
        else $error("register B lane wrong");

    // RQ8 third register to open collector
    reg_c_lane_a: assert property ( // RQ8
        modeThird[17:16] == 2'b10 && selectC[7:0] == 8'h13
        |=> openCollectorOut[0] == $past(sequencerOut[3]))
        else $error("open-collector routing wrong");

    // RQ9 last group shares the table
    last_group_a: assert property ( // RQ9
        modeDiff[23:22] == 2'b10 && selectC[31:24] == 8'h00
        |=> differentialOut[11] == $past(cameraControl[0]))
        else $error("group 11 table differs");

    // RQ6 write lands in first register
    write_a_a: assert property ( // RQ6
        doWrite && writeAddr == `OSS_ADDR_SELECT_A && writeStrb == 4'hF
        |=> selectA == $past(writeData) && s_axi_bvalid)
        else $error("register A write lost");

    cover_write_c: cover property (s_axi_bvalid && s_axi_bready);
    cover_read_c: cover property (s_axi_rvalid && s_axi_rready);
    cover_dyn_c: cover property (modeDiff[1:0] == 2'b10 ##1
        differentialOut[0]);
    cover_oc_c: cover property (openCollectorOut[0]);

endmodule // oss_output_source_select

/* File: tb/oss_box_equipment.sv */
// Far-side equipment model watching the box output drivers
`timescale 1ns/1ps

module oss_box_equipment (
    // Clock
    input wire logic clk_sys,
    // Box outputs as seen at the connector
    input wire logic [11:0] differentialOut,
    input wire logic [11:0] logicLevelOut,
    input wire logic [7:0] isolatedOut,
    input wire logic [3:0] openCollectorOut,
    // Per group: all three receivers saw one level
    output logic [11:0] groupAgree
);
    // ****************************************************************
    // Receivers
    // ****************************************************************
    logic [11:0] thirdLevel;

    // Third receiver is isolated for groups 0-7, open collector above
    assign thirdLevel = {openCollectorOut, isolatedOut};

    // Latch agreement each rising edge, as a slow receiver would
    always_ff @(posedge clk_sys) begin
        groupAgree <= ~(differentialOut ^ logicLevelOut) &
                      ~(differentialOut ^ thirdLevel);
    end
endmodule // oss_box_equipment

/* File: tb/tb_top.sv */
// Self-checking bench for the output source select block
`timescale 1ns/1ps
`include "oss_defines.svh"

module tb_top;
    import oss_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [15:0] cameraControl = 16'h0000;
    logic [3:0] sequencerOut = 4'h0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [35:0] boxOut [3];
    wire [11:0] groupAgree;
    int error_cnt = 0;
    int total_checks = 0;
    int grabbers [3] = '{4, 1, 3};

    // Clock at 100 MHz
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // Design instances: four, one and three grabbers
    // ****************************************************************
    oss_output_source_select #(.VARIANT(OSS_GRAB4)) DUT (
        .clk_sys(clk_sys), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cameraControl(cameraControl), .sequencerOut(sequencerOut),
        .differentialOut(boxOut[0][35:24]), .logicLevelOut(boxOut[0][23:12]),
        .openCollectorOut(boxOut[0][11:8]), .isolatedOut(boxOut[0][7:0])
    );
    oss_output_source_select #(.VARIANT(OSS_GRAB1)) DUT_g1 (
        .clk_sys(clk_sys), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
        .cameraControl(cameraControl), .sequencerOut(sequencerOut),
        .differentialOut(boxOut[1][35:24]), .logicLevelOut(boxOut[1][23:12]),
        .openCollectorOut(boxOut[1][11:8]), .isolatedOut(boxOut[1][7:0])
    );
    oss_output_source_select #(.VARIANT(OSS_GRAB3)) DUT_g3 (
        .clk_sys(clk_sys), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
        .cameraControl(cameraControl), .sequencerOut(sequencerOut),
        .differentialOut(boxOut[2][35:24]), .logicLevelOut(boxOut[2][23:12]),
        .openCollectorOut(boxOut[2][11:8]), .isolatedOut(boxOut[2][7:0])
    );
    oss_box_equipment EQUIP (
        .clk_sys(clk_sys), .differentialOut(boxOut[0][35:24]),
        .logicLevelOut(boxOut[0][23:12]), .isolatedOut(boxOut[0][7:0]),
        .openCollectorOut(boxOut[0][11:8]), .groupAgree(groupAgree)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic final_report();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [35:0] exp,
                       input logic [35:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // A used-up wait counts as a mismatch and ends the run
    task automatic timed_out(input int n);
        if (n >= 40) begin
            error_cnt++;
            $display("[ERR] handshake expected answer seen timeout");
            final_report();
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        bready <= 1'b0;
        timed_out(n);
        chk("bresp", 36'(er), 36'(bresp));
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
                            input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        rready <= 1'b0;
        timed_out(n);
        chk("rdata", 36'(ed), 36'(rdata));
        chk("rresp", 36'(er), 36'(rresp));
    endtask

    // Level a group should carry for a code on a variant
    function automatic logic exp_src(input logic [7:0] c, input int g,
                                     input logic [15:0] cc,
                                     input logic [3:0] sq);
        if (c < 8'h10) return (int'(c) / 4 < g) ? cc[c[3:0]] : 1'b0;
        if (c < 8'h14) return sq[c[1:0]];
        return 1'b0;
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic scen_reset();
        chk("outputs", 36'h0_0000_0000, boxOut[0]);
        axi_read(`OSS_ADDR_SELECT_A, 32'h0000_0000, OSS_OKAY);
        axi_read(`OSS_ADDR_SELECT_B, 32'h0000_0000, OSS_OKAY);
        axi_read(`OSS_ADDR_SELECT_C, 32'h0000_0000, OSS_OKAY);
    endtask

    // Low on differential, reserved on third, dynamic on logic-level and high on all three outputs, with the source held high
    task automatic scen_modes();
        cameraControl <= 16'hFFFF;
        sequencerOut <= 4'hF;
        axi_write(`OSS_ADDR_MODE_DIFF, 32'h0000_0000, 4'hF, OSS_OKAY);
        axi_write(`OSS_ADDR_MODE_LOGIC, 32'h0055_5555, 4'hF, OSS_OKAY);
        axi_write(`OSS_ADDR_MODE_THIRD, 32'h00FF_FFFF, 4'hF, OSS_OKAY);
        repeat (3) @(posedge clk_sys);
        chk("static", 36'h0_00FF_F000, boxOut[0]);
        axi_write(`OSS_ADDR_MODE_DIFF, 32'h0055_5555, 4'hF, OSS_OKAY);
        axi_write(`OSS_ADDR_MODE_LOGIC, 32'h00AA_AAAA, 4'hF, OSS_OKAY);
        axi_write(`OSS_ADDR_MODE_THIRD, 32'h0055_5555, 4'hF, OSS_OKAY);
        repeat (3) @(posedge clk_sys);
        chk("mixed", 36'hF_FFFF_FFFF, boxOut[0]);
        axi_write(`OSS_ADDR_MODE_DIFF, 32'h00AA_AAAA, 4'hF, OSS_OKAY);
        axi_write(`OSS_ADDR_MODE_THIRD, 32'h00AA_AAAA, 4'hF, OSS_OKAY);
    endtask

    // One code in all twelve fields; selected source high, then low
    task automatic scen_route(input logic [7:0] c);
        logic [19:0] src;
        logic e;
        axi_write(`OSS_ADDR_SELECT_A, {4{c}}, 4'hF, OSS_OKAY);
        axi_write(`OSS_ADDR_SELECT_B, {4{c}}, 4'hF, OSS_OKAY);
        axi_write(`OSS_ADDR_SELECT_C, {4{c}}, 4'hF, OSS_OKAY);
        src = (c < 8'h14) ? (20'h0_0001 << c) : 20'h0_0000;
        for (int ph = 0; ph < 2; ph++) begin
            cameraControl <= ph ? ~src[15:0] : src[15:0];
            sequencerOut <= ph ? ~src[19:16] : src[19:16];
            repeat (3) @(posedge clk_sys);
            for (int i = 0; i < 3; i++) begin
                e = exp_src(c, grabbers[i], cameraControl, sequencerOut);
                chk("route", {36{e}}, boxOut[i]);
            end
        end
        chk("agree", 36'h0_0000_0FFF, 36'(groupAgree));
    endtask

    // Byte lanes to groups, strobes, status and refused places
    task automatic scen_lanes();
        logic [11:0] d;
        axi_write(`OSS_ADDR_SELECT_A, 32'h0302_0100, 4'hF, OSS_OKAY);
        axi_write(`OSS_ADDR_SELECT_B, 32'h0706_0504, 4'hF, OSS_OKAY);
        axi_write(`OSS_ADDR_SELECT_C, 32'h0B0A_0908, 4'hF, OSS_OKAY);
        axi_read(`OSS_ADDR_SELECT_B, 32'h0706_0504, OSS_OKAY);
        axi_read(`OSS_ADDR_SELECT_C, 32'h0B0A_0908, OSS_OKAY);
        axi_read(`OSS_ADDR_STATUS, 32'h0002_0FFF, OSS_OKAY);
        sequencerOut <= 4'h0;
        for (int g = 0; g < 12; g++) begin
            cameraControl <= 16'h0001 << g;
            repeat (3) @(posedge clk_sys);
            for (int i = 0; i < 3; i++) begin
                d = (g / 4 < grabbers[i]) ? (12'h001 << g) : 12'h000;
                chk("lane", {d, d, d}, boxOut[i]);
            end
        end
        axi_write(`OSS_ADDR_SELECT_A, 32'hFFFF_13FF, 4'h2, OSS_OKAY);
        axi_read(`OSS_ADDR_SELECT_A, 32'h0302_1300, OSS_OKAY);
        axi_write(8'h1C, 32'hFFFF_FFFF, 4'hF, OSS_SLVERR);
        axi_read(8'h1C, 32'h0000_0000, OSS_SLVERR);
        axi_write(`OSS_ADDR_STATUS, 32'h0000_0000, 4'hF, OSS_SLVERR);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        scen_reset();
        scen_modes();
        for (int c = 0; c < 21; c++) scen_route(8'(c));
        scen_route(8'h24);
        scen_route(8'hFF);
        scen_lanes();
        final_report();
    end
endmodule // tb_top
